// [rtl/drive_input_consts.svh]
// timing counts, register offsets, field positions and reset values
`ifndef DRIVE_INPUT_CONSTS_SVH
`define DRIVE_INPUT_CONSTS_SVH
// clock rate in kHz (125 MHz)
`define CLK_KHZ 125000
// reset pulse least width in ms, and its count (least time, rounds up)
`define RST_MIN_MS 12
`define RST_MIN_CYC (`RST_MIN_MS * `CLK_KHZ)
// alarm clear deadline in ms
`define ALARM_CLR_MS 30
`define ALARM_CLR_CYC (`ALARM_CLR_MS * `CLK_KHZ)
// extra hold of delayed outputs after reset, in ms
`define OFF_HOLD_MS 1000
`define OFF_HOLD_CYC (`OFF_HOLD_MS * `CLK_KHZ)
// stop key window after power-up, in ms
`define KEY_WIN_MS 3000
`define KEY_WIN_CYC (`KEY_WIN_MS * `CLK_KHZ)
// register byte offsets
`define REG_CTRL 12'h000
`define REG_STAT 12'h004
`define REG_PARAM 12'h008
`define REG_FREQ 12'h00C
`define REG_OUTCFG 12'h010
`define REG_ID 12'h014
// control field positions
`define CTRL_FREQ_EXEMPT 0
`define CTRL_SRC_ANALOG 1
`define CTRL_RUN 2
`define CTRL_TRIP_SET 3
`define CTRL_KEY_CLEAR 4
// status field positions
`define STAT_LOCK 0
`define STAT_SEL_CUR 1
`define STAT_TRIP 2
`define STAT_MOTOR 3
`define STAT_RESETTING 4
`define STAT_KEY_WIN 5
`define STAT_REF_SRC_LO 6
// reset values
`define CTRL_RESET 32'h00000001
`define PARAM_RESET 32'h00000000
`define FREQ_RESET 32'h00000000
`define OUTCFG_RESET 32'h00000000
// arbitrary identity value
`define ID_VALUE 32'h0D1F0001
`endif

// [rtl/drive_input_pkg.sv]
// types shared by the input terminal design
package drive_input_pkg;
    // reset sequence states
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_HELD = 4'b0010,
        ST_SHORT = 4'b0100,
        ST_RELEASE = 4'b1000
    } rst_state_t;
    // frequency reference source
    typedef enum logic [1:0] {
        REF_DIGITAL = 2'h0,
        REF_VOLTAGE = 2'h1,
        REF_CURRENT = 2'h2
    } ref_src_t;
endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic level_o
);
    // first stage, read only by the second
    logic meta_q;
    // two flops in series
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 1'b0;
            level_o <= 1'b0;
        end else begin
            meta_q <= pin_i;
            level_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [rtl/off_delay.sv]
// one logic output with optional off delay after reset
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.svh"
module off_delay (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic want_i,
    input wire logic delay_en_i,
    input wire logic reset_i,
    output logic out_o
);
    // hold counter width for one second at 125 MHz
    logic [27:0] hold_q;
    // reset input one cycle earlier, to find reset start
    logic reset_prev_q;
    // output level and hold
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_o <= 1'b0;
            hold_q <= 28'h0;
            reset_prev_q <= 1'b0;
        end else begin
            reset_prev_q <= reset_i;
            if (!reset_i) begin
                // normal pass-through
                out_o <= want_i;
                hold_q <= 28'h0;
            end else if (!reset_prev_q) begin
                out_o <= out_o & delay_en_i;
                hold_q <= 28'(`OFF_HOLD_CYC - 1);
            end else if (hold_q != 28'h0) begin
                // still holding
                hold_q <= hold_q - 28'h1;
            end else begin
                out_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/drive_inputs.sv]
// input terminal functions of a motor drive: lock, analog select, reset
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.svh"
module drive_inputs (
    input wire logic clock_i,
    input wire logic nrst_i,
    // terminal pins
    input wire logic parameter_lock_input_i,
    input wire logic analog_source_select_input_i,
    input wire logic trip_clear_input_i,
    // keypad edit strobe and values
    input wire logic key_edit_i,
    input wire logic key_freq_i,
    input wire logic [15:0] key_value_i,
    input wire logic key_stop_i,
    input wire logic remote_attached_i,
    // analog readings, same clock
    input wire logic [9:0] voltage_ref_i,
    input wire logic [9:0] current_reference_input_i,
    // fault source, same clock
    input wire logic fault_i,
    // wanted logic outputs
    input wire logic [2:0] logic_want_i,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive outputs
    output logic motor_on_o,
    output logic alarm_o,
    output logic [9:0] freq_ref_o,
    output logic [2:0] logic_out_o
);
    // synchronised pin levels
    logic lock_s;
    logic sel_s;
    logic rst_s;
    // control, parameter, frequency, output config registers
    logic [31:0] ctrl_q;
    logic [31:0] param_q;
    logic [15:0] freq_q;
    logic [2:0] outcfg_q;
    // trip state and reset machine
    logic trip_q;
    drive_input_pkg::rst_state_t st_q;
    logic [21:0] width_q;
    logic [28:0] key_win_q;
    logic por_q;
    // bus latches
    logic aw_q;
    logic w_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_ok;
    logic sw_frq_ok;
    logic reset_active;
    drive_input_pkg::ref_src_t src;

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pin synchronisers
    pin_sync u_lock (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(parameter_lock_input_i),
                     .level_o(lock_s));
    pin_sync u_sel (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(analog_source_select_input_i),
                    .level_o(sel_s));
    pin_sync u_rst (.clock_i(clock_i), .nrst_i(nrst_i), .pin_i(trip_clear_input_i),
                    .level_o(rst_s));
    // reset sequence active in held state or either release state
    assign reset_active = (st_q != drive_input_pkg::ST_RUN);
    // edit permit when unlocked, frequency also if exempt
    assign wr_ok = !lock_s;
    assign sw_frq_ok = !lock_s || ctrl_q[`CTRL_FREQ_EXEMPT];
    // write accepted once address and data both held
    assign wr_fire = aw_q && w_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    // write channel capture and response
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                // both taken: answer, slverr on status, id, unmapped or locked
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_q)
                    `REG_CTRL, `REG_OUTCFG: s_axi_bresp <= 2'h0;
                    `REG_PARAM: s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
                    `REG_FREQ: s_axi_bresp <= sw_frq_ok ? 2'h0 : 2'h2;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // control and output config registers, never locked
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= `CTRL_RESET;
            outcfg_q <= 3'h0;
        end else if (wr_fire && awaddr_q == `REG_CTRL) begin
            ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
        end else if (wr_fire && awaddr_q == `REG_OUTCFG) begin
            outcfg_q <= wdata_q[2:0];
        end
    end
    // parameter store, from bus or keypad
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            param_q <= `PARAM_RESET;
        end else if (wr_fire && awaddr_q == `REG_PARAM && wr_ok) begin
            param_q <= merge(param_q, wdata_q, wstrb_q);
        end else if (key_edit_i && !key_freq_i && wr_ok) begin
            param_q <= {16'h0000, key_value_i};
        end
    end
    // frequency setting, exempt per control bit
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_q <= 16'h0000;
        end else if (wr_fire && awaddr_q == `REG_FREQ && sw_frq_ok) begin
            freq_q <= 16'(merge({16'h0000, freq_q}, wdata_q, wstrb_q));
        end else if (key_edit_i && key_freq_i && sw_frq_ok) begin
            freq_q <= key_value_i;
        end
    end
    always_comb begin
        if (!ctrl_q[`CTRL_SRC_ANALOG]) begin
            src = drive_input_pkg::REF_DIGITAL;
        end else if (sel_s) begin
            src = drive_input_pkg::REF_CURRENT;
        end else begin
            src = drive_input_pkg::REF_VOLTAGE;
        end
    end
    // frequency reference follows levels every cycle
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_ref_o <= 10'h000;
        end else begin
            unique case (src)
                drive_input_pkg::REF_CURRENT: freq_ref_o <= current_reference_input_i;
                drive_input_pkg::REF_VOLTAGE: freq_ref_o <= voltage_ref_i;
                default: freq_ref_o <= freq_q[9:0];
            endcase
        end
    end
    // power-on flag, released one cycle after reset
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            por_q <= 1'b1;
        end else begin
            por_q <= 1'b0;
        end
    end
    // reset sequence machine
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= drive_input_pkg::ST_HELD;
            width_q <= 22'h0;
        end else begin
            unique case (st_q)
                drive_input_pkg::ST_RUN: begin
                    if (rst_s) begin
                        st_q <= drive_input_pkg::ST_HELD;
                        width_q <= 22'h0;
                    end
                end
                drive_input_pkg::ST_HELD: begin
                    if (width_q != 22'(`RST_MIN_CYC)) begin
                        width_q <= width_q + 22'h1;
                    end
                    if (!rst_s && !por_q) begin
                        st_q <= (width_q == 22'(`RST_MIN_CYC)) ?
                                drive_input_pkg::ST_RELEASE : drive_input_pkg::ST_SHORT;
                    end
                end
                // either release path rejoins normal running
                drive_input_pkg::ST_SHORT, drive_input_pkg::ST_RELEASE: begin
                    st_q <= drive_input_pkg::ST_RUN;
                end
            endcase
        end
    end
    // trip state: set by fault, cleared by reset
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trip_q <= 1'b0;
        end else if (fault_i || (wr_fire && awaddr_q == `REG_CTRL &&
                                 wdata_q[`CTRL_TRIP_SET] && wstrb_q[0])) begin
            // set wins over clear
            trip_q <= 1'b1;
        end else if (st_q == drive_input_pkg::ST_HELD && width_q == 22'(`RST_MIN_CYC)) begin
            trip_q <= 1'b0;
        end else if (key_stop_i && (!remote_attached_i || key_win_q != 29'h0)) begin
            // stop key clears at any time, or only within its window when remote attached
            trip_q <= 1'b0;
        end
    end
    // alarm follows trip, cleared at 12 ms, inside 30 ms
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_o <= 1'b0;
        end else begin
            alarm_o <= trip_q;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_win_q <= 29'(`KEY_WIN_CYC);
        end else if (key_win_q != 29'h0) begin
            key_win_q <= key_win_q - 29'h1;
        end
    end

    // motor output: off in reset, coasting, restarts on run
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            motor_on_o <= 1'b0;
        end else if (reset_active || rst_s || trip_q) begin
            motor_on_o <= 1'b0;
        end else begin
            motor_on_o <= ctrl_q[`CTRL_RUN];
        end
    end

    // logic outputs with off delay
    for (genvar g = 0; g < 3; g++) begin : g_out
        off_delay u_od (.clock_i(clock_i), .nrst_i(nrst_i), .want_i(logic_want_i[g]),
                        .delay_en_i(outcfg_q[g]), .reset_i(reset_active),
                        .out_o(logic_out_o[g]));
    end

    // read channel
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
                `REG_CTRL: s_axi_rdata <= ctrl_q;
                `REG_STAT: s_axi_rdata <= {24'h0, src, key_win_q != 29'h0, reset_active,
                                           motor_on_o, trip_q, sel_s, lock_s};
                `REG_PARAM: s_axi_rdata <= param_q;
                `REG_FREQ: s_axi_rdata <= {16'h0000, freq_q};
                `REG_OUTCFG: s_axi_rdata <= {29'h0, outcfg_q};
                `REG_ID: s_axi_rdata <= `ID_VALUE;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verif/drive_inputs_monitor.sv]
// assertion checker for the drive input terminal block
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.svh"
module drive_inputs_monitor (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic parameter_lock_input_i,
    input wire logic analog_source_select_input_i,
    input wire logic trip_clear_input_i,
    input wire logic [9:0] voltage_ref_i,
    input wire logic [9:0] current_reference_input_i,
    input wire logic [2:0] logic_want_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic motor_on_o,
    input wire logic [9:0] freq_ref_o,
    input wire logic [2:0] logic_out_o
);
    // last write address and data
    logic [11:0] aw_q;
    logic [31:0] wd_q;
    // copies of control bits and delay enables
    logic [1:0] ctrl_q;
    logic [2:0] cfg_q;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    // copies follow each accepted write response
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_q <= 12'h000;
            wd_q <= 32'h00000000;
            ctrl_q <= 2'h1;
            cfg_q <= 3'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
            if ($rose(s_axi_bvalid) && s_axi_bresp == 2'h0) begin
                if (aw_q == `REG_CTRL) ctrl_q <= wd_q[1:0];
                if (aw_q == `REG_OUTCFG) cfg_q <= wd_q[2:0];
            end
        end
    end
    a_motor_held: assert property (trip_clear_input_i [*6] |-> !motor_on_o)
        else $error("motor on while reset input held");
    a_outputs_off: assert property (trip_clear_input_i [*6]
        |-> (logic_out_o & ~cfg_q) == 3'h0)
        else $error("undelayed output on during reset");
    a_delay_hold: assert property ($rose(trip_clear_input_i) && cfg_q[0] && logic_out_o[0]
        && logic_want_i[0] |-> logic_out_o[0] [*8]) else $error("delayed output dropped early");
    a_param_locked: assert property ($rose(s_axi_bvalid) && aw_q == `REG_PARAM
        && $past(parameter_lock_input_i, 3) && $past(parameter_lock_input_i, 8)
        |-> s_axi_bresp == 2'h2) else $error("locked parameter write accepted");
    a_param_open: assert property ($rose(s_axi_bvalid) && aw_q == `REG_PARAM
        && !$past(parameter_lock_input_i, 3) && !$past(parameter_lock_input_i, 8)
        |-> s_axi_bresp == 2'h0) else $error("unlocked parameter write refused");
    a_freq_exempt: assert property ($rose(s_axi_bvalid) && aw_q == `REG_FREQ
        && $past(parameter_lock_input_i, 3) && $past(parameter_lock_input_i, 8)
        |-> s_axi_bresp == (ctrl_q[0] ? 2'h0 : 2'h2)) else $error("frequency lock wrong");
    a_sel_current: assert property ((ctrl_q[1] && analog_source_select_input_i
        && $stable(current_reference_input_i)) [*6] |-> freq_ref_o == current_reference_input_i)
        else $error("current input not used");
    a_sel_voltage: assert property ((ctrl_q[1] && !analog_source_select_input_i
        && $stable(voltage_ref_i)) [*6] |-> freq_ref_o == voltage_ref_i)
        else $error("voltage input not used");
    // main scenarios reached
    c_refused: cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h2);
    c_current: cover property (ctrl_q[1] && analog_source_select_input_i);
    c_held: cover property (trip_clear_input_i && logic_out_o[0] && cfg_q[0]);
endmodule
bind drive_inputs drive_inputs_monitor u_mon (.clock_i(clock_i), .nrst_i(nrst_i),
    .parameter_lock_input_i(parameter_lock_input_i),
    .analog_source_select_input_i(analog_source_select_input_i),
    .trip_clear_input_i(trip_clear_input_i), .voltage_ref_i(voltage_ref_i),
    .current_reference_input_i(current_reference_input_i), .logic_want_i(logic_want_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .motor_on_o(motor_on_o),
    .freq_ref_o(freq_ref_o), .logic_out_o(logic_out_o));
`default_nettype wire

// [verif/reset_contact.sv]
// external relay model driving the reset terminal
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.svh"
module reset_contact #(
    parameter int HOLD_CYC = `RST_MIN_CYC
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic want_i,
    input wire logic short_ok_i,
    output logic pin_o
);
    // cycles the contact has been closed
    int held_q;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o <= 1'b0;
            held_q <= 0;
        end else if (want_i || (pin_o && !short_ok_i && held_q < HOLD_CYC)) begin
            pin_o <= 1'b1;
            held_q <= held_q + 1;
        end else begin
            pin_o <= 1'b0;
            held_q <= 0;
        end
    end
endmodule
`default_nettype wire

// [verif/drive_inputs_tb.sv]
// self-checking bench for the drive input terminal block
`timescale 1ns/1ps
`default_nettype none
`include "drive_input_consts.svh"
module drive_inputs_tb;
    // clock, reset, terminal and keypad stimulus
    logic clk = 1'b0, nrst = 1'b0, lock = 1'b0, sel = 1'b0, want_rs = 1'b0, short_ok = 1'b0;
    logic key_ed = 1'b0, key_frq = 1'b0, key_stop = 1'b0, remote = 1'b0, rs_pin;
    logic [15:0] key_val = 16'h0000;
    logic [9:0] volt = 10'h000, cur = 10'h000, fref;
    logic [2:0] want = 3'h0, lout;
    // bus master side
    logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
    logic [31:0] w_d = 32'h00000000, r_d, v, p;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, motor, alarm;
    logic [1:0] b_resp, r_resp;
    // expected bus results and tallies
    logic [1:0] exp_b[$];
    logic [65:0] exp_r[$];
    logic [65:0] e;
    int err_total = 0, total_checks = 0, seed = 6718;
    always #4 clk = ~clk;
    reset_contact u_rs (.clock_i(clk), .nrst_i(nrst), .want_i(want_rs), .short_ok_i(short_ok),
        .pin_o(rs_pin));
    drive_inputs DUT (.clock_i(clk), .nrst_i(nrst), .parameter_lock_input_i(lock),
        .analog_source_select_input_i(sel), .trip_clear_input_i(rs_pin), .key_edit_i(key_ed),
        .key_freq_i(key_frq), .key_value_i(key_val), .key_stop_i(key_stop),
        .remote_attached_i(remote), .voltage_ref_i(volt), .current_reference_input_i(cur),
        .fault_i(1'b0), .logic_want_i(want), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .motor_on_o(motor),
        .alarm_o(alarm), .freq_ref_o(fref), .logic_out_o(lout));
    // one comparison, counted
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bus write, expected response noted first
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
        b_r <= 1'b0;
        @(posedge clk);
    endtask
    // bus read with compare mask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic [1:0] r);
        exp_r.push_back({r, m, x});
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_rdy) ar_v <= 1'b0;
        end while (!r_v);
        r_r <= 1'b0;
        @(posedge clk);
    endtask
    // watcher: oldest note against each response
    always @(posedge clk) begin
        if (b_v && b_r) cmp({30'h0, b_resp}, {30'h0, exp_b.pop_front()});
        if (r_v && r_r) begin
            e = exp_r.pop_front();
            cmp({30'h0, r_resp}, {30'h0, e[65:64]});
            cmp(r_d & e[63:32], e[31:0]);
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmp(32'(motor), 32'h0);
        tick(12);
        // reset values, unmapped place
        rd(`REG_CTRL, 32'hFFFFFFFF, `CTRL_RESET, 2'h0);
        rd(`REG_PARAM, 32'hFFFFFFFF, `PARAM_RESET, 2'h0);
        rd(`REG_FREQ, 32'hFFFFFFFF, `FREQ_RESET, 2'h0);
        rd(`REG_OUTCFG, 32'hFFFFFFFF, `OUTCFG_RESET, 2'h0);
        rd(`REG_ID, 32'hFFFFFFFF, `ID_VALUE, 2'h0);
        rd(`REG_STAT, 32'h000000DF, 32'h00000000, 2'h0);
        rd(12'h018, 32'hFFFFFFFF, 32'h00000000, 2'h2);
        wr(12'h018, 32'h00000001, 2'h2);
        $display("register test done");
        // lock: parameter refused, keypad ignored, frequency exempt
        lock <= 1'b1;
        tick(6);
        rd(`REG_STAT, 32'h00000001, 32'h00000001, 2'h0);
        v = $random(seed);
        wr(`REG_PARAM, v, 2'h2);
        key_val <= v[15:0];
        key_ed <= 1'b1;
        tick(1);
        key_ed <= 1'b0;
        rd(`REG_PARAM, 32'hFFFFFFFF, 32'h00000000, 2'h0);
        wr(`REG_FREQ, v & 32'h0000FFFF, 2'h0);
        wr(`REG_CTRL, 32'h00000000, 2'h0);
        wr(`REG_FREQ, 32'h00000000, 2'h2);
        key_val <= ~v[15:0];
        key_frq <= 1'b1;
        key_ed <= 1'b1;
        tick(1);
        key_ed <= 1'b0;
        key_frq <= 1'b0;
        rd(`REG_FREQ, 32'h0000FFFF, v & 32'h0000FFFF, 2'h0);
        lock <= 1'b0;
        tick(6);
        p = $random(seed);
        wr(`REG_PARAM, p, 2'h0);
        rd(`REG_PARAM, 32'hFFFFFFFF, p, 2'h0);
        key_frq <= 1'b1;
        key_ed <= 1'b1;
        tick(1);
        key_ed <= 1'b0;
        key_frq <= 1'b0;
        rd(`REG_FREQ, 32'h0000FFFF, {16'h0000, ~v[15:0]}, 2'h0);
        $display("lock test done");
        // analog select between current and voltage
        volt <= 10'($random(seed));
        cur <= 10'($random(seed));
        wr(`REG_CTRL, 32'h00000002, 2'h0);
        sel <= 1'b1;
        tick(6);
        cmp(32'(fref), 32'(cur));
        rd(`REG_STAT, 32'h000000C2, 32'h00000082, 2'h0);
        sel <= 1'b0;
        tick(6);
        cmp(32'(fref), 32'(volt));
        wr(`REG_CTRL, 32'h00000000, 2'h0);
        sel <= 1'b1;
        tick(6);
        rd(`REG_STAT, 32'h000000C2, 32'h00000002, 2'h0);
        $display("select test done");
        // trip, key clear, restart, short reset pulse
        want <= 3'h7;
        wr(`REG_CTRL, 32'h00000005, 2'h0);
        tick(4);
        cmp({28'h0, motor, lout}, 32'h0000000F);
        wr(`REG_CTRL, 32'h0000000D, 2'h0);
        tick(3);
        cmp({30'h0, alarm, motor}, 32'h00000002);
        remote <= 1'b1;
        key_stop <= 1'b1;
        tick(1);
        key_stop <= 1'b0;
        tick(2);
        cmp(32'(alarm), 32'h0);
        tick(4);
        cmp(32'(motor), 32'h1);
        wr(`REG_OUTCFG, 32'h00000001, 2'h0);
        short_ok <= 1'b1;
        want_rs <= 1'b1;
        tick(8);
        cmp({28'h0, motor, lout}, 32'h00000001);
        tick(40);
        cmp(32'(lout), 32'h1);
        want_rs <= 1'b0;
        tick(12);
        cmp(32'(motor), 32'h1);
        $display("reset test done");
        close_out();
    end
endmodule
`default_nettype wire
